// file: hw/cst_pkg.sv
// types shared by the serial timing block
package cst_pkg;
    typedef enum logic [1:0] {CST_DIRECT, CST_FIFO, CST_DUAL, CST_TXONLY} cst_mem_t;
    typedef enum logic [1:0] {CST_RX, CST_TX, CST_TXRX, CST_DIR_RSVD} cst_dir_t;
    typedef enum {CST_IDLE, CST_SETUP, CST_SHIFT, CST_GAP, CST_HOLD, CST_REST} cst_state_t;
endpackage

// file: hw/cst_regs.svh
// register offsets, field positions and timing counts of the serial timing block
`ifndef CST_REGS_SVH
`define CST_REGS_SVH
`define CST_STATUS_0 8'h00
`define CST_MEM_CTL_0 8'h04
`define CST_SER_CTL_1 8'h08
`define CST_MEM_CTL_2 8'h0C
`define CST_CS_CFG 8'h10
`define CST_TX_DATA 8'h14
`define CST_RX_DATA 8'h18
`define CST_IRQ_STATUS 8'h1C
`define CST_IRQ_MASK 8'h20
`define CST_TSF_BIT 7
`define CST_BTST_BIT 31
`define CST_HALF_BIT 3
`define CST_ENABLE_BIT 4
`define CST_MODE_LSB 8
`define CST_FRAME_EDGES 5'h10
`define CST_TICK_DIV 4
// half serial clock steps for codes 0..15, code 0 in the low six bits
`define CST_STEP_TABLE {6'h29, 6'h25, 6'h21, 6'h1D, 6'h19, 6'h17, 6'h15, 6'h13, \
    6'h11, 6'h0D, 6'h09, 6'h07, 6'h05, 6'h03, 6'h02, 6'h01}
`endif

// file: hw/cst_sync.sv
// two-flop synchronisers, one per bit
`timescale 1ns/1ns
`default_nettype none
module cst_sync #(parameter int W = 2) (
    input wire logic pclk,
    input wire logic presetn,
    cst_sync_if.dst p
);
    logic [W-1:0] meta;
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta[i] <= 1'b0;
                p.sync[i] <= 1'b0;
            end else begin
                meta[i] <= p.raw[i];
                p.sync[i] <= meta[i];
            end
        end
    end
endmodule
`default_nettype wire

// file: hw/cst_sync_if.sv
// raw pin levels and their synchronised copies
`timescale 1ns/1ns
`default_nettype none
interface cst_sync_if #(parameter int W = 2);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport src (output raw, input sync);
    modport dst (input raw, output sync);
endinterface
`default_nettype wire

// file: hw/cst_tick.sv
// divider giving one enable pulse per half serial clock
`timescale 1ns/1ns
`default_nettype none
module cst_tick #(parameter int DIV = 4) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic tick
);
    logic [7:0] cnt;
    if (DIV < 2 || DIV > 255) begin : g_bad_div
        $error("cst_tick: DIV out of range");
    end
    // restarting on run keeps the first half period whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
            tick <= 1'b0;
        end else if (!run || cnt == 8'(DIV - 1)) begin
            cnt <= 8'h00;
            tick <= run;
        end else begin
            cnt <= cnt + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: hw/cst_top.sv
// one channel: status flag, timeout, chip-select timing and completion events
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cst_regs.svh"
// How it works
// R1: direct or FIFO mode, transmit directions: writing transmit data sets the flag
// R2: dual or transmit-only buffer mode: the buffer start bit sets the flag
// R3: the flag clears within half a serial clock after the last edge
// R4: slave receive-only, direct or FIFO: flag sets when serial clock toggles
// R5: five-bit timeout field picks clock cycles before a FIFO timeout
// R6: three-bit idle field inserts 0.5 to 8.5 clock cycles of idle
// R7: four-bit hold field gives 0.5 to 20.5 cycles of chip-select hold
// R8: extra half cycle bit adds half a cycle to every hold code
// R9: completion events drive all three DMA trigger outputs and the interrupt path
// R10: inter-data field gives 0.0 to 20.0 cycle gaps, plus half when set
// R11: setup field delays first clock edge 0.5 to 20.5 cycles after select
module cst_top import cst_pkg::*; #(parameter int TICK_DIV = `CST_TICK_DIV) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic sdi,
    output logic sdo,
    output logic cs_n,
    output logic irq,
    output logic [2:0] dma_req
);
    localparam logic [95:0] STEPS = `CST_STEP_TABLE;
    logic [4:0] timeout_sel;
    cst_mem_t mem_mode;
    logic master, half_sel, enable;
    cst_dir_t dir;
    logic [14:0] cfg;
    logic [7:0] tx_buf, rx_data, shreg;
    logic [3:0] irq_st, irq_mask, ev;
    logic tsf, tx_pend, tick, wr, rd;
    cst_state_t state;
    logic [5:0] dly;
    logic [4:0] edges;
    logic [4:0] to_cnt;
    logic to_armed;
    logic sclk_s, sclk_d, sdi_s, sclk_edge, last_edge;
    cst_sync_if #(.W(2)) syn ();

    // the divider cannot make a half period shorter than two clocks
    if (TICK_DIV < 2 || TICK_DIV > 255) begin : g_bad_div
        $error("cst_top: TICK_DIV out of range");
    end

    // one table serves setup, hold, gap and idle; setup, hold and gap add their own offsets, idle uses it as is
    function automatic logic [5:0] steps(input logic [3:0] code);
        steps = STEPS[6*code +: 6];
    endfunction

    assign syn.raw = {sdi, sclk_in};
    assign sclk_s = syn.sync[0];
    assign sdi_s = syn.sync[1];

    cst_sync #(.W(2)) u_sync (.pclk(pclk), .presetn(presetn), .p(syn));
    cst_tick #(.DIV(TICK_DIV)) u_tick (.pclk(pclk), .presetn(presetn),
        .run(master && enable && state != CST_IDLE), .tick(tick));

    // apb: one wait state so read data can come from a flop
    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && penable && !pwrite && !pready;
    wire tx_wr = wr && paddr == `CST_TX_DATA;
    wire btst_wr = wr && paddr == `CST_MEM_CTL_2 && pwdata[`CST_BTST_BIT];
    wire tx_dir = dir == CST_TX || dir == CST_TXRX;
    wire fifo_like = mem_mode == CST_DIRECT || mem_mode == CST_FIFO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready) begin
                case (paddr)
                    `CST_STATUS_0: prdata[`CST_TSF_BIT] <= tsf;
                    `CST_MEM_CTL_0: prdata <= {22'h0, mem_mode, 3'h0, timeout_sel};
                    `CST_SER_CTL_1: prdata <= {27'h0, enable, half_sel, dir, master};
                    `CST_MEM_CTL_2: prdata <= 32'h0000_0000;
                    `CST_CS_CFG: prdata <= {17'h0, cfg};
                    `CST_TX_DATA: prdata <= {24'h0, tx_buf};
                    `CST_RX_DATA: if (rd) prdata <= {24'h0, rx_data};
                    `CST_IRQ_STATUS: prdata <= {28'h0, irq_st};
                    `CST_IRQ_MASK: prdata <= {28'h0, irq_mask};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_sel <= 5'h00;
            mem_mode <= CST_DIRECT;
            master <= 1'b0;
            dir <= CST_TXRX;
            half_sel <= 1'b0;
            enable <= 1'b0;
            cfg <= 15'h0000;
            tx_buf <= 8'h00;
            irq_mask <= 4'h0;
        end else if (wr) begin
            case (paddr)
                `CST_MEM_CTL_0: begin
                    timeout_sel <= pwdata[4:0];
                    mem_mode <= cst_mem_t'(pwdata[`CST_MODE_LSB +: 2]);
                end
                `CST_SER_CTL_1: begin
                    master <= pwdata[0];
                    dir <= cst_dir_t'(pwdata[2:1]);
                    half_sel <= pwdata[`CST_HALF_BIT];
                    enable <= pwdata[`CST_ENABLE_BIT];
                end
                `CST_CS_CFG: cfg <= pwdata[14:0];
                `CST_TX_DATA: tx_buf <= pwdata[7:0];
                `CST_IRQ_MASK: irq_mask <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // sclk edges as seen by the slave, after the synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sclk_d <= 1'b0;
        else sclk_d <= sclk_s;
    end
    assign sclk_edge = !master && enable && (sclk_s != sclk_d);
    assign last_edge = master ? (state == CST_SHIFT && tick && edges == `CST_FRAME_EDGES - 5'h01)
                              : (sclk_edge && edges == `CST_FRAME_EDGES - 5'h01);

    wire set_tsf = enable && ((fifo_like && tx_dir && tx_wr)                      // see R1
        || (!fifo_like && btst_wr)                                                // see R2
        || (!master && fifo_like && dir == CST_RX && sclk_edge && edges == 5'h00)); // see R4

    // set wins over the end-of-frame clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tsf <= 1'b0;
        else if (set_tsf) tsf <= 1'b1;
        else if (last_edge) tsf <= 1'b0; // see R3
    end

    // a trigger during a frame is remembered here and becomes the next byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tx_pend <= 1'b0;
        else if (set_tsf && master) tx_pend <= 1'b1;
        else if ((state == CST_SETUP || state == CST_GAP) && dly == 6'h00) tx_pend <= 1'b0;
    end

    // master sequencer, every delay counted in half serial clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= CST_IDLE;
            dly <= 6'h00;
            cs_n <= 1'b1;
        end else if (!master || !enable) begin
            state <= CST_IDLE;
            dly <= 6'h00;
            cs_n <= 1'b1;
        end else begin
            case (state)
                CST_IDLE: if (tx_pend) begin
                    state <= CST_SETUP;
                    cs_n <= 1'b0;
                    // the tick that launches the first edge is the last half step
                    dly <= steps(cfg[3:0]) - 6'h01; // see R11
                end
                CST_SETUP, CST_GAP: if (dly == 6'h00) state <= CST_SHIFT;
                    else if (tick) dly <= dly - 6'h01;
                CST_SHIFT: if (last_edge) begin
                    if (tx_pend) begin
                        state <= CST_GAP;
                        dly <= steps(cfg[7:4]) - 6'h01 + {5'h00, half_sel}; // see R10
                    end else begin
                        state <= CST_HOLD;
                        dly <= steps(cfg[11:8]) + {5'h00, half_sel}; // see R7 R8
                    end
                end
                CST_HOLD: if (dly == 6'h00) begin
                    state <= CST_REST;
                    cs_n <= 1'b1;
                    dly <= steps({1'b0, cfg[14:12]}); // see R6
                end else if (tick) dly <= dly - 6'h01;
                CST_REST: if (dly == 6'h00) state <= CST_IDLE;
                    else if (tick) dly <= dly - 6'h01;
                default: state <= CST_IDLE;
            endcase
        end
    end

    // shifter: drive on falling edge, sample on rising edge, msb first
    wire step = master ? (state == CST_SHIFT && tick) : sclk_edge;
    wire rising = master ? !sclk_out : sclk_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edges <= 5'h00;
            shreg <= 8'h00;
            sdo <= 1'b0;
            sclk_out <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            if ((master && state != CST_SHIFT) || (!master && tx_wr)) begin
                edges <= 5'h00;
                shreg <= tx_buf;
                sdo <= tx_buf[7];
                if (!master && tx_wr) begin
                    shreg <= pwdata[7:0];
                    sdo <= pwdata[7];
                end
            end else if (step) begin
                edges <= last_edge ? 5'h00 : edges + 5'h01;
                if (rising) shreg <= {shreg[6:0], sdi_s};
                else sdo <= shreg[7];
                // the sixteenth edge is a falling one: all eight bits are already in
                if (last_edge) rx_data <= shreg;
            end
            if (master && state == CST_SHIFT && tick) sclk_out <= !sclk_out;
            else if (state != CST_SHIFT) sclk_out <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sclk_oe <= 1'b0;
        else sclk_oe <= master && enable;
    end

    // fifo timeout: pclk cycles of silence after a received frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_cnt <= 5'h00;
            to_armed <= 1'b0;
        end else if (last_edge || step) begin
            to_cnt <= 5'h00;
            to_armed <= mem_mode == CST_FIFO && timeout_sel != 5'h00;
        end else if (to_armed) begin
            to_cnt <= to_cnt + 5'h01;
            if (to_cnt == timeout_sel - 5'h01) to_armed <= 1'b0; // see R5
        end
    end

    wire job_end = master ? (state == CST_HOLD && dly == 6'h00) : last_edge;
    always_comb begin
        ev[0] = last_edge && tx_dir;
        ev[1] = last_edge && dir != CST_TX;
        ev[2] = job_end;
        ev[3] = to_armed && to_cnt == timeout_sel - 5'h01;
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st <= 4'h0;
            irq <= 1'b0;
            dma_req <= 3'h0;
        end else begin
            irq_st <= (irq_st & ~((wr && paddr == `CST_IRQ_STATUS) ? pwdata[3:0] : 4'h0)) | ev;
            irq <= |(irq_st & irq_mask);
            dma_req <= ev[2:0]; // see R9
        end
    end

    tsf_set_a: assert property (@(posedge pclk) disable iff (!presetn) // see R1
        enable && fifo_like && tx_dir && tx_wr |=> tsf)
        else $error("flag not set by transmit write");
    btst_set_a: assert property (@(posedge pclk) disable iff (!presetn) // see R2
        enable && !fifo_like && btst_wr |=> tsf)
        else $error("flag not set by buffer start");
    tsf_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
        last_edge && !set_tsf |=> !tsf)
        else $error("flag not cleared after last edge");
    slave_rx_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
        enable && !master && fifo_like && dir == CST_RX && sclk_edge && edges == 5'h00 |=> tsf)
        else $error("flag not set by serial clock input");
    timeout_a: assert property (@(posedge pclk) disable iff (!presetn) // see R5
        ev[3] |-> to_cnt + 5'h01 == timeout_sel && mem_mode == CST_FIFO)
        else $error("timeout at wrong count");
    idle_time_a: assert property (@(posedge pclk) disable iff (!presetn) // see R6
        $changed(state) && state == CST_REST |-> dly == steps({1'b0, cfg[14:12]}))
        else $error("idle time mismatch");
    hold_time_a: assert property (@(posedge pclk) disable iff (!presetn) // see R7
        $changed(state) && state == CST_HOLD |-> cs_n == 1'b0
        && dly == steps(cfg[11:8]) + {5'h00, half_sel})
        else $error("hold time mismatch");
    hold_half_a: assert property (@(posedge pclk) disable iff (!presetn) // see R8
        $changed(state) && state == CST_HOLD && half_sel && cfg[11:8] == 4'h0 |-> dly == 6'h02)
        else $error("extra half cycle missing");
    dma_event_a: assert property (@(posedge pclk) disable iff (!presetn) // see R9
        ev[2] |=> dma_req[2] && irq_st[2])
        else $error("job event not routed");
    gap_time_a: assert property (@(posedge pclk) disable iff (!presetn) // see R10
        $changed(state) && state == CST_GAP |-> !cs_n
        && dly == steps(cfg[7:4]) - 6'h01 + {5'h00, half_sel})
        else $error("inter-data gap mismatch");
    setup_time_a: assert property (@(posedge pclk) disable iff (!presetn) // see R11
        $rose(!cs_n) |-> state == CST_SETUP && dly == steps(cfg[3:0]) - 6'h01)
        else $error("setup delay mismatch");

    frame_c: cover property (@(posedge pclk) disable iff (!presetn) state == CST_HOLD);
    gap_c: cover property (@(posedge pclk) disable iff (!presetn) state == CST_GAP);
    slave_c: cover property (@(posedge pclk) disable iff (!presetn) !master && last_edge);
    timeout_c: cover property (@(posedge pclk) disable iff (!presetn) ev[3]);
    idle_c: cover property (@(posedge pclk) disable iff (!presetn)
        state == CST_REST && cfg[14:12] == 3'h7);

    // bus, pin and interrupt behaviour around the timing logic
    pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held longer than one cycle");
    slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error response without ready");
    cs_released_a: assert property (@(posedge pclk) disable iff (!presetn)
        !master || !enable |=> cs_n)
        else $error("chip select low while not master");
    sclk_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        state != CST_SHIFT |=> !sclk_out)
        else $error("serial clock not idle low");
    sclk_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
        master && enable |=> sclk_oe)
        else $error("serial clock output not enabled");
    irq_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_st & irq_mask) != 4'h0 |=> irq)
        else $error("unmasked event without interrupt");
    irq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_st & irq_mask) == 4'h0 |=> !irq)
        else $error("interrupt without unmasked event");
    job_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // see R9
        dma_req[2] |=> !dma_req[2])
        else $error("job request longer than one cycle");
endmodule
`default_nettype wire

// file: test/cst_peer.sv
// serial peer: captures sdo, drives sdi, acts as clock master on request
`timescale 1ns/1ns
`default_nettype none
module cst_peer (
    input wire logic cs_n,
    input wire logic sclk_out,
    input wire logic sdo,
    input wire logic go,
    input wire logic [7:0] tx_byte,
    output logic sclk_in,
    output logic sdi,
    output logic [7:0] rx_byte
);
    logic [7:0] sh = 8'h00;
    logic drv = 1'b0;
    wire logic ck = drv ? sclk_in : sclk_out;
    initial begin
        sclk_in = 1'b0;
        sdi = 1'b0;
        rx_byte = 8'h00;
    end
    always @(posedge ck) rx_byte <= {rx_byte[6:0], sdo};
    always @(negedge cs_n) begin
        sh = tx_byte;
        sdi = tx_byte[7];
    end
    always @(negedge ck) begin
        sh = {sh[6:0], 1'b0};
        sdi = sh[7];
    end
    // released line shows the inverse so a stale sample cannot pass
    always @(posedge cs_n) sdi = ~sdi;
    // odd start offset keeps the link clock out of phase with pclk
    always @(posedge go) begin
        drv = 1'b1;
        sh = tx_byte;
        sdi = tx_byte[7];
        #173;
        repeat (8) begin
            sclk_in = 1'b1;
            #160;
            sclk_in = 1'b0;
            #160;
        end
        drv = 1'b0;
        sdi = ~sdi;
    end
endmodule
`default_nettype wire

// file: test/cst_top_tb.sv
// self-checking bench for the serial timing channel
`timescale 1ns/1ns
`default_nettype none
`include "cst_regs.svh"
module cst_top_tb;
    localparam int TD = 4;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sclk_in, sclk_out, sclk_oe, sdi, sdo, cs_n, irq, err;
    logic [2:0] dma_req;
    logic [7:0] rx_byte;
    int n_errors = 0, num_checks = 0, cyc = 0, t_csf, t_first, t_last, t_csr, t_irq;
    int max_gap, n_edge;
    int n_dma [3] = '{0, 0, 0};
    bit first = 0, sck_q = 0, cs_q = 1, irq_q = 0;
    int tbl [16] = '{1, 2, 3, 5, 7, 9, 13, 17, 19, 21, 23, 25, 29, 33, 37, 41};
    int cases [6][5] = '{'{0, 0, 0, 0, 0}, '{15, 15, 0, 1, 0}, '{3, 7, 0, 0, 0},
        '{0, 0, 0, 0, 1}, '{0, 2, 15, 1, 1}, '{1, 4, 6, 0, 1}};
    cst_top #(.TICK_DIV(TD)) cst_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk_in), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .sdi(sdi), .sdo(sdo), .cs_n(cs_n), .irq(irq), .dma_req(dma_req));
    cst_peer cst_peer_i (.cs_n(cs_n), .sclk_out(sclk_out), .sdo(sdo), .go(go),
        .tx_byte(8'h3C), .sclk_in(sclk_in), .sdi(sdi), .rx_byte(rx_byte));
    initial forever #20 pclk = ~pclk;
    // edge timestamps in pclk cycles, taken from settled values
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        cs_q <= cs_n;
        sck_q <= sclk_out;
        irq_q <= irq;
        for (int i = 0; i < 3; i++) if (dma_req[i] === 1'b1) n_dma[i] <= n_dma[i] + 1;
        if (!irq_q && irq === 1'b1) t_irq <= cyc;
        if (cs_q && cs_n === 1'b0) begin
            t_csf <= cyc;
            first <= 1;
            n_edge <= 0;
            max_gap <= 0;
        end
        if (!cs_q && cs_n === 1'b1) t_csr <= cyc;
        if (sck_q !== sclk_out) begin
            n_edge <= n_edge + 1;
            t_last <= cyc;
            if (first) t_first <= cyc;
            else if (cyc - t_last > max_gap) max_gap <= cyc - t_last;
            first <= 0;
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", nm, e, g);
        end
    endtask
    // durations carry a few cycles of synchroniser and register slack
    task automatic near(input string nm, input int e, input int g);
        num_checks++;
        if (g < e - 3 || g > e + 3) begin
            n_errors++;
            $display("[ERR] %s exp %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("pready", 1, 0);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e, input string nm);
        apb(0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask
    task automatic wait_hi();
        int n;
        n = 0;
        while (cs_n !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) chk("cs_n rise", 1, 0);
        repeat (4) @(posedge pclk);
    endtask
    task automatic frame(input int sp, hd, gp, h, input bit two);
        apb(1, `CST_IRQ_STATUS, 32'hF);
        n_dma = '{0, 0, 0};
        apb(1, `CST_CS_CFG, 32'({hd[3:0], gp[3:0], sp[3:0]}));
        apb(1, `CST_SER_CTL_1, 32'h15 | 32'(h << 3));
        apb(1, `CST_TX_DATA, 32'hA5);
        rdchk(`CST_STATUS_0, 32'h80, 32'h80, "tsf set");
        if (two) apb(1, `CST_TX_DATA, 32'h5A);
        wait_hi();
        chk("sclk_oe", 1, sclk_oe);
        near("setup", tbl[sp] * TD, t_first - t_csf);
        near("hold", (tbl[hd] + h) * TD, t_csr - t_last);
        chk("edges", two ? 32 : 16, n_edge);
        chk("peer rx", two ? 8'h5A : 8'hA5, rx_byte);
        rdchk(`CST_STATUS_0, 32'h80, 32'h0, "tsf clear");
        rdchk(`CST_IRQ_STATUS, 32'h7, 32'h7, "events");
        if (two) near("gap", (tbl[gp] + h) * TD, max_gap);
        else begin
            rdchk(`CST_RX_DATA, 32'hFF, 32'h3C, "rx data");
            for (int i = 0; i < 3; i++) chk("dma", 1, n_dma[i]);
        end
    endtask
    initial begin
        #2000000;
        chk("watchdog", 0, 1);
        stop_test();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`CST_SER_CTL_1, 32'h1F, 32'h4, "ctl1 reset");
        rdchk(`CST_CS_CFG, 32'hFFFFFFFF, 32'h0, "cfg reset");
        apb(0, 8'h40, 32'h0);
        chk("slverr", 1, err);
        apb(1, `CST_CS_CFG, 32'h7FFF);
        rdchk(`CST_CS_CFG, 32'hFFFFFFFF, 32'h7FFF, "cfg rw");
        apb(1, `CST_SER_CTL_1, 32'h05);
        apb(1, `CST_TX_DATA, 32'h11);
        repeat (10) @(posedge pclk);
        chk("disabled", 1, cs_n);
        foreach (cases[i]) frame(cases[i][0], cases[i][1], cases[i][2], cases[i][3], cases[i][4]);
        rdchk(`CST_IRQ_STATUS, 32'h8, 32'h0, "no timeout");
        apb(1, `CST_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq on", 1, irq);
        apb(1, `CST_IRQ_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq masked", 0, irq);
        apb(1, `CST_IRQ_MASK, 32'h1);
        apb(1, `CST_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 0, irq);
        rdchk(`CST_IRQ_STATUS, 32'hF, 32'h6, "w1c");
        apb(1, `CST_IRQ_MASK, 32'h8);
        apb(1, `CST_MEM_CTL_0, 32'h11F);
        frame(0, 0, 0, 0, 0);
        repeat (40) @(posedge pclk);
        near("timeout", 31, t_irq - t_last);
        apb(1, `CST_IRQ_MASK, 32'h0);
        apb(1, `CST_MEM_CTL_0, 32'h200);
        apb(1, `CST_TX_DATA, 32'h11);
        rdchk(`CST_STATUS_0, 32'h80, 32'h0, "dual no tsf");
        apb(1, `CST_MEM_CTL_2, 32'h80000000);
        rdchk(`CST_STATUS_0, 32'h80, 32'h80, "dual tsf");
        wait_hi();
        apb(1, `CST_MEM_CTL_0, 32'h0);
        apb(1, `CST_CS_CFG, 32'h7000);
        apb(1, `CST_TX_DATA, 32'h11);
        rdchk(`CST_STATUS_0, 32'h80, 32'h80, "tsf idle");
        wait_hi();
        apb(1, `CST_TX_DATA, 32'h22);
        while (cs_n !== 1'b0) @(posedge pclk);
        repeat (2) @(posedge pclk);
        near("idle", tbl[7] * TD, t_csf - t_csr);
        wait_hi();
        apb(1, `CST_SER_CTL_1, 32'h10);
        go <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("sclk_oe off", 0, sclk_oe);
        rdchk(`CST_STATUS_0, 32'h80, 32'h80, "slave tsf");
        repeat (80) @(posedge pclk);
        rdchk(`CST_STATUS_0, 32'h80, 32'h0, "slave clear");
        rdchk(`CST_RX_DATA, 32'hFF, 32'h3C, "slave rx");
        go <= 1'b0;
        stop_test();
    end
endmodule
`default_nettype wire
